/* File: rtl/mps_pkg.sv */
// Shared constants and types for the multi-segment position sequencer
package mps_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam logic [9:0] DWELL_UNIT1_MS = 10'h3E8;

  // ==========================================================
  // Sizes
  localparam int SEG_N = 16;
  localparam int SPEED_W = 13;

  // ==========================================================
  // Register word addresses (byte address is four times these)
  localparam logic [6:0] ADDR_CTRL = 7'h00;
  localparam logic [6:0] ADDR_STATUS = 7'h01;
  localparam logic [6:0] ADDR_POS = 7'h02;
  localparam int TBL_BIT = 6;
  localparam int TBL_SEG_LO = 2;
  localparam logic [1:0] FLD_DISP = 2'h0;
  localparam logic [1:0] FLD_SPEED = 2'h1;
  localparam logic [1:0] FLD_RAMP = 2'h2;
  localparam logic [1:0] FLD_DWELL = 2'h3;

  // ==========================================================
  // Control word layout
  localparam int CTRL_SRC = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_FIRST_LO = 4;
  localparam int CTRL_LAST_LO = 9;
  localparam int CTRL_POLICY = 16;
  localparam int CTRL_KIND = 17;
  localparam int CTRL_UNIT = 18;

  // ==========================================================
  // Status word layout
  localparam int STS_COMPLETE = 0;
  localparam int STS_RUNNING = 1;
  localparam int STS_SEG_LO = 2;
  localparam int STS_STATE_LO = 8;
  localparam int STS_EN = 12;
  localparam int STS_REFUSED = 13;

  // ==========================================================
  // Reset values of each segment record
  localparam logic [31:0] DEF_DISP = 32'h0000_2710;
  localparam logic [12:0] DEF_SPEED = 13'h0064;
  localparam logic [15:0] DEF_RAMP = 16'h0064;
  localparam logic [15:0] DEF_DWELL = 16'h0064;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_CYCLIC = 2'h1,
    MODE_SELECT = 2'h2
  } mps_mode_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOAD = 3'h1,
    ST_MOVE = 3'h3,
    ST_DWELL = 3'h2,
    ST_DONE = 3'h6,
    ST_STOP = 3'h7
  } mps_state_e;

endpackage

/* File: rtl/mps_prof_if.sv */
// Link between the sequencer and its motion profile engine
`timescale 1ns/1ps
interface mps_prof_if;
  logic start;
  logic abort;
  logic [31:0] target;
  logic [12:0] speed;
  logic [15:0] ramp;
  logic busy;
  logic [31:0] pos;

  modport ctl (output start, output abort, output target, output speed,
               output ramp, input busy, input pos);
  modport eng (input start, input abort, input target, input speed,
               input ramp, output busy, output pos);
endinterface

/* File: rtl/mps_sync.sv */
// Two-stage synchroniser for the digital input pins
`timescale 1ns/1ps
module mps_sync (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [4:0] async_i,
  output logic [4:0] sync_o
);

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
  } mps_sync_s;

  mps_sync_s r;
  mps_sync_s next_r;

  // ==========================================================
  // Stages
  always_comb begin
    next_r = r;
    next_r.s1 = async_i;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_o = r.s2;

endmodule

/* File: rtl/mps_profile.sv */
// Trapezoid motion profile engine for one segment
`timescale 1ns/1ps
module mps_profile (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  mps_prof_if.eng pif
);

  typedef struct packed {
    logic [31:0] pos;
    logic [31:0] tgt;
    logic [12:0] vel;
    logic [6:0] us_cnt;
    logic [15:0] ramp_cnt;
    logic moving;
  } mps_prof_s;

  mps_prof_s r;
  mps_prof_s next_r;

  // ==========================================================
  // Profile step
  always_comb begin
    logic us_tick;
    logic upd;
    logic [32:0] rem;
    logic [32:0] mag;
    logic [26:0] brake;
    logic [12:0] spd;
    logic [12:0] vel_n;
    logic [32:0] step;
    us_tick = 1'b0;
    upd = 1'b0;
    rem = '0;
    mag = '0;
    brake = '0;
    spd = '0;
    vel_n = '0;
    step = '0;
    next_r = r;
    us_tick = (r.us_cnt == 7'(mps_pkg::US_CYCLES - 1));
    next_r.us_cnt = us_tick ? 7'h00 : r.us_cnt + 7'h01;
    if (us_tick) begin
      if (r.ramp_cnt + 16'h0001 >= pif.ramp) begin
        upd = 1'b1;
        next_r.ramp_cnt = 16'h0000;
      end else begin
        next_r.ramp_cnt = r.ramp_cnt + 16'h0001;
      end
    end
    rem = {r.tgt[31], r.tgt} - {r.pos[31], r.pos};
    mag = rem[32] ? 33'(-rem) : rem;
    brake = 27'((27'(r.vel) * 27'({1'b0, r.vel} + 14'h0001)) >> 1);
    spd = (pif.speed == 13'h0000) ? 13'h0001 : pif.speed;
    vel_n = r.vel;
    if ((mag <= 33'(brake) || r.vel > spd) && r.vel != 13'h0000) begin
      vel_n = r.vel - 13'h0001;
    end else if (r.vel < spd) begin
      vel_n = r.vel + 13'h0001;
    end
    step = (mag < 33'(vel_n)) ? mag : 33'(vel_n);
    if (pif.start) begin
      next_r.tgt = pif.target;
      next_r.moving = 1'b1;
      next_r.vel = 13'h0000;
      next_r.ramp_cnt = 16'h0000;
    end else if (pif.abort) begin
      // Unfinished distance is dropped; speed still ramps down
      next_r.tgt = r.pos;
    end else if (r.moving && upd) begin
      next_r.vel = vel_n;
      next_r.pos = rem[32] ? r.pos - step[31:0] : r.pos + step[31:0];
    end
    // Done only with full distance issued and speed at zero
    if (!pif.start && r.moving && mag == 33'h0 && r.vel == 13'h0000) begin
      next_r.moving = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign pif.busy = r.moving;
  assign pif.pos = r.pos;

endmodule

/* File: rtl/mps_sequencer.sv */
// Multi-segment position sequencer with Avalon-MM register slave
// ==========================================================
//
// The placing of the registers and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module mps_sequencer #(
  parameter int MS_CYCLES = mps_pkg::MS_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic sequence_run_enable_i,
  input wire logic [3:0] segment_select_i,
  output logic positioning_complete_o,
  output logic sequence_running_o,
  output logic [3:0] active_segment_o,
  output logic [31:0] position_cmd_o
);

  typedef struct packed {
    logic waitreq;
    logic [31:0] rdata;
    logic position_source_select;
    mps_pkg::mps_mode_e sequence_run_mode;
    logic [3:0] first_segment_index;
    logic [3:0] last_segment_index;
    logic interrupt_resume_policy;
    logic displacement_kind;
    logic dwell_unit_select;
    logic [15:0][31:0] disp;
    logic [15:0][12:0] speed;
    logic [15:0][15:0] ramp;
    logic [15:0][15:0] dwell;
    mps_pkg::mps_state_e state;
    logic [3:0] seg;
    logic [3:0] resume_seg;
    logic resume_vld;
    logic start;
    logic abort;
    logic [31:0] target;
    logic [12:0] cmd_speed;
    logic [15:0] cmd_ramp;
    logic [16:0] ms_cnt;
    logic [9:0] unit_cnt;
    logic [15:0] dwell_cnt;
    logic complete;
    logic running;
    logic refused;
  } mps_top_s;

  mps_top_s r;
  mps_top_s next_r;
  logic [4:0] pins_sync;
  logic en_s;
  logic [3:0] sel_s;

  mps_prof_if pif ();

  // ==========================================================
  // Pin synchronisers and profile engine
  mps_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({segment_select_i, sequence_run_enable_i}),
    .sync_o(pins_sync)
  );

  assign en_s = pins_sync[0];
  assign sel_s = pins_sync[4:1];

  mps_profile u_profile (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .pif(pif.eng)
  );

  // ==========================================================
  // Helpers
  function automatic logic [3:0] idx_of(input logic [4:0] v);
    logic [4:0] t;
    t = v - 5'h01;
    return t[3:0];
  endfunction

  function automatic logic [4:0] num_of(input logic [3:0] i);
    return {1'b0, i} + 5'h01;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction

  function automatic logic [31:0] ctrl_word(input mps_top_s s);
    logic [31:0] w;
    w = '0;
    w[mps_pkg::CTRL_SRC] = s.position_source_select;
    w[mps_pkg::CTRL_MODE_LO +: 2] = s.sequence_run_mode;
    w[mps_pkg::CTRL_FIRST_LO +: 5] = num_of(s.first_segment_index);
    w[mps_pkg::CTRL_LAST_LO +: 5] = num_of(s.last_segment_index);
    w[mps_pkg::CTRL_POLICY] = s.interrupt_resume_policy;
    w[mps_pkg::CTRL_KIND] = s.displacement_kind;
    w[mps_pkg::CTRL_UNIT] = s.dwell_unit_select;
    return w;
  endfunction

  function automatic logic [31:0] tbl_word(input mps_top_s s,
                                           input logic [3:0] i,
                                           input logic [1:0] f);
    logic [31:0] w;
    w = '0;
    case (f)
      mps_pkg::FLD_DISP: w = s.disp[i];
      mps_pkg::FLD_SPEED: w = {19'h0_0000, s.speed[i]};
      mps_pkg::FLD_RAMP: w = {16'h0000, s.ramp[i]};
      default: w = {16'h0000, s.dwell[i]};
    endcase
    return w;
  endfunction

  // ==========================================================
  // Bus slave, register file and sequencer
  always_comb begin
    logic active;
    logic ms_tick;
    logic dwell_tick;
    logic launch;
    logic [3:0] launch_seg;
    logic [3:0] seg_after;
    logic [3:0] a_seg;
    logic [1:0] a_fld;
    logic [31:0] w;
    logic refuse;
    active = 1'b0;
    ms_tick = 1'b0;
    dwell_tick = 1'b0;
    launch = 1'b0;
    launch_seg = r.seg;
    seg_after = '0;
    a_seg = avs_address_i[mps_pkg::TBL_SEG_LO +: 4];
    a_fld = avs_address_i[1:0];
    w = '0;
    refuse = 1'b0;
    next_r = r;
    next_r.start = 1'b0;
    next_r.abort = 1'b0;

    // Request seen while waiting: answer next cycle with data
    if (r.waitreq && (avs_read_i || avs_write_i)) begin
      next_r.waitreq = 1'b0;
      if (avs_read_i) begin
        if (avs_address_i[mps_pkg::TBL_BIT]) begin
          next_r.rdata = tbl_word(r, a_seg, a_fld);
        end else if (avs_address_i == mps_pkg::ADDR_CTRL) begin
          next_r.rdata = ctrl_word(r);
        end else if (avs_address_i == mps_pkg::ADDR_STATUS) begin
          w[mps_pkg::STS_COMPLETE] = r.complete;
          w[mps_pkg::STS_RUNNING] = r.running;
          w[mps_pkg::STS_SEG_LO +: 5] = num_of(r.seg);
          w[mps_pkg::STS_STATE_LO +: 3] = r.state;
          w[mps_pkg::STS_EN] = en_s;
          w[mps_pkg::STS_REFUSED] = r.refused;
          next_r.rdata = w;
        end else if (avs_address_i == mps_pkg::ADDR_POS) begin
          next_r.rdata = pif.pos;
        end else begin
          next_r.rdata = 32'h0000_0000;
        end
      end
    end else begin
      next_r.waitreq = 1'b1;
    end

    // Write takes effect on the edge where waitrequest is low
    if (!r.waitreq && avs_write_i) begin
      if (avs_address_i == mps_pkg::ADDR_STATUS) begin
        if (avs_writedata_i[mps_pkg::STS_REFUSED] && avs_byteenable_i[1]) begin
          next_r.refused = 1'b0;
        end
      end else if (en_s) begin
        refuse = 1'b1;
      end else if (avs_address_i[mps_pkg::TBL_BIT]) begin
        w = merge(tbl_word(r, a_seg, a_fld), avs_writedata_i,
                  avs_byteenable_i);
        case (a_fld)
          mps_pkg::FLD_DISP: next_r.disp[a_seg] = w;
          mps_pkg::FLD_SPEED: next_r.speed[a_seg] = w[12:0];
          mps_pkg::FLD_RAMP: next_r.ramp[a_seg] = w[15:0];
          default: next_r.dwell[a_seg] = w[15:0];
        endcase
      end else if (avs_address_i == mps_pkg::ADDR_CTRL) begin
        w = merge(ctrl_word(r), avs_writedata_i, avs_byteenable_i);
        next_r.position_source_select = w[mps_pkg::CTRL_SRC];
        next_r.sequence_run_mode =
          mps_pkg::mps_mode_e'(w[mps_pkg::CTRL_MODE_LO +: 2]);
        next_r.first_segment_index =
          idx_of(w[mps_pkg::CTRL_FIRST_LO +: 5]);
        next_r.last_segment_index =
          idx_of(w[mps_pkg::CTRL_LAST_LO +: 5]);
        next_r.interrupt_resume_policy = w[mps_pkg::CTRL_POLICY];
        next_r.displacement_kind = w[mps_pkg::CTRL_KIND];
        next_r.dwell_unit_select = w[mps_pkg::CTRL_UNIT];
      end
    end

    // Time base for dwell: 1 ms, or DWELL_UNIT1_MS of them
    ms_tick = (r.ms_cnt == 17'(MS_CYCLES - 1));
    next_r.ms_cnt = ms_tick ? 17'h0_0000 : r.ms_cnt + 17'h0_0001;
    if (!r.dwell_unit_select) begin
      dwell_tick = ms_tick;
    end else if (ms_tick) begin
      dwell_tick = (r.unit_cnt == mps_pkg::DWELL_UNIT1_MS - 10'h001);
      next_r.unit_cnt = dwell_tick ? 10'h000 : r.unit_cnt + 10'h001;
    end

    active = r.position_source_select && en_s;
    seg_after = (r.seg == r.last_segment_index) ?
                r.first_segment_index : r.seg + 4'h1;

    case (r.state)
      mps_pkg::ST_IDLE: begin
        if (active) begin
          launch = 1'b1;
          if (r.sequence_run_mode == mps_pkg::MODE_SELECT) begin
            launch_seg = sel_s;
          end else begin
            launch_seg = (r.resume_vld && !r.interrupt_resume_policy) ?
                         r.resume_seg : r.first_segment_index;
          end
          next_r.resume_vld = 1'b0;
        end
      end
      mps_pkg::ST_LOAD: begin
        next_r.state = mps_pkg::ST_MOVE;
      end
      mps_pkg::ST_MOVE: begin
        if (!active) begin
          next_r.abort = 1'b1;
          next_r.state = mps_pkg::ST_STOP;
        end else if (!pif.busy) begin
          if (r.sequence_run_mode == mps_pkg::MODE_SELECT) begin
            next_r.state = mps_pkg::ST_DONE;
          end else if (r.sequence_run_mode == mps_pkg::MODE_SINGLE &&
                       r.seg == r.last_segment_index) begin
            next_r.state = mps_pkg::ST_DONE;
          end else begin
            next_r.dwell_cnt = r.dwell[r.seg];
            next_r.unit_cnt = 10'h000;
            next_r.state = mps_pkg::ST_DWELL;
          end
        end
      end
      mps_pkg::ST_DWELL: begin
        if (!active) begin
          next_r.resume_seg = r.interrupt_resume_policy ?
                              r.first_segment_index : seg_after;
          next_r.resume_vld = 1'b1;
          next_r.state = mps_pkg::ST_IDLE;
        end else if (r.dwell_cnt == 16'h0000) begin
          launch = 1'b1;
          launch_seg = seg_after;
        end else if (dwell_tick) begin
          next_r.dwell_cnt = r.dwell_cnt - 16'h0001;
        end
      end
      mps_pkg::ST_STOP: begin
        if (!pif.busy) begin
          if (r.interrupt_resume_policy) begin
            next_r.resume_seg = r.first_segment_index;
          end else begin
            next_r.resume_seg = seg_after;
          end
          next_r.resume_vld = 1'b1;
          next_r.state = mps_pkg::ST_IDLE;
        end
      end
      mps_pkg::ST_DONE: begin
        // Rerun needs the enable to drop and return
        if (!active) begin
          next_r.resume_vld = 1'b0;
          next_r.state = mps_pkg::ST_IDLE;
        end
      end
      default: begin
        next_r.state = mps_pkg::ST_IDLE;
      end
    endcase

    if (launch) begin
      next_r.seg = launch_seg;
      next_r.start = 1'b1;
      next_r.cmd_speed = r.speed[launch_seg];
      next_r.cmd_ramp = r.ramp[launch_seg];
      if (r.displacement_kind) begin
        next_r.target = r.disp[launch_seg];
      end else begin
        next_r.target = pif.pos + r.disp[launch_seg];
      end
      next_r.state = mps_pkg::ST_LOAD;
    end

    // Set wins over a clear arriving in the same cycle
    if (refuse) begin
      next_r.refused = 1'b1;
    end

    next_r.complete = !pif.busy && !next_r.start &&
                      (next_r.state == mps_pkg::ST_IDLE ||
                       next_r.state == mps_pkg::ST_DWELL ||
                       next_r.state == mps_pkg::ST_DONE);
    next_r.running = (next_r.state != mps_pkg::ST_IDLE) &&
                     (next_r.state != mps_pkg::ST_DONE);
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r <= '0;
      r.waitreq <= 1'b1;
      r.disp <= {mps_pkg::SEG_N{mps_pkg::DEF_DISP}};
      r.speed <= {mps_pkg::SEG_N{mps_pkg::DEF_SPEED}};
      r.ramp <= {mps_pkg::SEG_N{mps_pkg::DEF_RAMP}};
      r.dwell <= {mps_pkg::SEG_N{mps_pkg::DEF_DWELL}};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign pif.start = r.start;
  assign pif.abort = r.abort;
  assign pif.target = r.target;
  assign pif.speed = r.cmd_speed;
  assign pif.ramp = r.cmd_ramp;

  assign avs_readdata_o = r.rdata;
  assign avs_waitrequest_o = r.waitreq;
  assign positioning_complete_o = r.complete;
  assign sequence_running_o = r.running;
  assign active_segment_o = r.seg;
  assign position_cmd_o = pif.pos;

endmodule

/* File: test/mps_host_model.sv */
// Host controller model driving the enable and select pins
`timescale 1ns/1ps
module mps_host_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic want_en_i,
  input wire logic [3:0] want_sel_i,
  output logic sequence_run_enable_o,
  output logic [3:0] segment_select_o
);
  // =========================================================
  // Pins move only on the clock, like a scanned output card
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sequence_run_enable_o <= 1'b0;
      segment_select_o <= 4'h0;
    end else begin
      sequence_run_enable_o <= want_en_i;
      segment_select_o <= want_sel_i;
    end
  end
endmodule

/* File: test/mps_sequencer_monitor.sv */
// Port checker for the multi-segment position sequencer
`timescale 1ns/1ps
module mps_sequencer_monitor #(
  parameter int MS_CYCLES = 50
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic sequence_run_enable_i,
  input wire logic positioning_complete_o,
  input wire logic sequence_running_o,
  input wire logic [3:0] active_segment_o,
  input wire logic [31:0] position_cmd_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // =========================================================
  // Bus answers
  a_wait_answer: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  a_wait_single: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("bus answer too long");
  a_answer_cause: assert property (
    !avs_waitrequest_o |-> $past(avs_read_i) || $past(avs_write_i))
    else $error("bus answer without request");
  // =========================================================
  // Motion
  a_run_busy: assert property (
    $rose(sequence_running_o) |-> !positioning_complete_o)
    else $error("complete during start");
  a_pos_hold: assert property (
    !sequence_running_o && !$past(sequence_running_o) &&
    !$past(sequence_running_o, 2) |-> $stable(position_cmd_o))
    else $error("position moved while idle");
  a_enable_start: assert property (
    $rose(sequence_running_o) |-> $past(sequence_run_enable_i, 2))
    else $error("run without enable");
  // Deceleration is short in the bench setup, so 1000 cycles is ample
  a_stop_done: assert property (
    !sequence_run_enable_i [*4] |-> ##[0:1000] positioning_complete_o)
    else $error("no complete after stop");
  a_seg_hold: assert property (
    $changed(active_segment_o) |-> sequence_running_o)
    else $error("segment changed while idle");
endmodule
bind mps_sequencer mps_sequencer_monitor #(.MS_CYCLES(MS_CYCLES)) u_mon (
  .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .sequence_run_enable_i(sequence_run_enable_i),
  .positioning_complete_o(positioning_complete_o),
  .sequence_running_o(sequence_running_o),
  .active_segment_o(active_segment_o), .position_cmd_o(position_cmd_o));

/* File: test/mps_sequencer_test.sv */
// Self-checking bench for the multi-segment position sequencer
`timescale 1ns/1ps
module mps_sequencer_test;
  // =========================================================
  // Signals
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic want_en = 1'b0;
  logic wait_o, en_pin, cmp, run;
  logic [6:0] adr = 7'h00;
  logic [3:0] want_sel = 4'h0;
  logic [3:0] sel_pin, seg;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, pos, q;
  logic [31:0] disp [16];
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #4 sys_clk_i = ~sys_clk_i;
  mps_sequencer #(.MS_CYCLES(50)) u_dut (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .sequence_run_enable_i(en_pin),
    .segment_select_i(sel_pin), .positioning_complete_o(cmp),
    .sequence_running_o(run), .active_segment_o(seg),
    .position_cmd_o(pos));
  mps_host_model u_host (
    .sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .want_en_i(want_en),
    .want_sel_i(want_sel), .sequence_run_enable_o(en_pin),
    .segment_select_o(sel_pin));
  // =========================================================
  // Shared tasks
  task summarize;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    // Only the bench timeout ends a stuck wait
    do begin
      @(posedge sys_clk_i);
    end while (wait_o !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task set_en(input logic v);
    @(posedge sys_clk_i);
    want_en <= v;
  endtask
  task wait_run(input logic v);
    int n;
    n = 0;
    while (run !== v && n < 6000) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 6000) errors++;
  endtask
  task next_seg(input logic [3:0] e);
    logic [3:0] old;
    int n;
    old = seg;
    n = 0;
    while (seg === old && n < 6000) begin
      @(posedge sys_clk_i);
      n++;
    end
    check({28'h0, seg}, {28'h0, e});
  endtask
  function automatic logic [31:0] ctl(input logic s, input logic [1:0] m,
    input logic [4:0] f, input logic [4:0] l, input logic p, input logic k);
    ctl = {14'h0, k, p, 2'h0, l, f, 1'b0, m, s};
  endfunction
  // =========================================================
  // Scenarios
  task t_defaults;
    bus(0, mps_pkg::ADDR_CTRL, 0);
    check(q, 32'h0000_0210);
    for (int s = 0; s < 16; s += 15) begin
      bus(0, {1'b1, 4'(s), 2'h0}, 0);
      check(q, 32'h0000_2710);
      bus(0, {1'b1, 4'(s), 2'h1}, 0);
      check(q, 32'h0000_0064);
      bus(0, {1'b1, 4'(s), 2'h2}, 0);
      check(q, 32'h0000_0064);
      bus(0, {1'b1, 4'(s), 2'h3}, 0);
      check(q, 32'h0000_0064);
    end
    bus(0, 7'h03, 0);
    check(q, 32'h0000_0000);
  endtask
  // Slow speed and short ramp keep each move under about 1200 cycles
  task t_setup;
    logic [3:0] ids [5];
    ids = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF};
    foreach (ids[i]) begin
      bus(1, {1'b1, ids[i], 2'h0}, disp[ids[i]]);
      bus(1, {1'b1, ids[i], 2'h1}, 32'h0000_0002);
      bus(1, {1'b1, ids[i], 2'h2}, 32'h0000_0001);
      bus(1, {1'b1, ids[i], 2'h3}, 32'h0000_0001);
    end
    bus(0, {1'b1, 4'h2, 2'h0}, 0);
    check(q, 32'hFFFF_FFFE);
  endtask
  task t_source;
    bus(1, mps_pkg::ADDR_CTRL, ctl(0, 0, 1, 2, 0, 0));
    set_en(1);
    repeat (40) @(posedge sys_clk_i);
    check({31'h0, run}, 32'h0000_0000);
    set_en(0);
    repeat (4) @(posedge sys_clk_i);
  endtask
  task t_single;
    bus(1, mps_pkg::ADDR_CTRL, ctl(1, 0, 2, 3, 0, 0));
    set_en(1);
    wait_run(1);
    bus(1, mps_pkg::ADDR_CTRL, ctl(1, 1, 1, 4, 0, 0));
    wait_run(0);
    check(pos, 32'h0000_0001);
    check({28'h0, seg}, 32'h0000_0002);
    repeat (300) @(posedge sys_clk_i);
    check({31'h0, run}, 32'h0000_0000);
    bus(0, mps_pkg::ADDR_CTRL, 0);
    check(q, ctl(1, 0, 2, 3, 0, 0));
    bus(0, mps_pkg::ADDR_STATUS, 0);
    check({31'h0, q[13]}, 32'h0000_0001);
    set_en(0);
    repeat (4) @(posedge sys_clk_i);
    bus(1, mps_pkg::ADDR_STATUS, 32'h0000_2000);
    bus(0, mps_pkg::ADDR_STATUS, 0);
    check({31'h0, q[13]}, 32'h0000_0000);
  endtask
  task t_cyclic;
    bus(1, mps_pkg::ADDR_CTRL, ctl(1, 1, 1, 3, 0, 0));
    set_en(1);
    wait_run(1);
    repeat (3) @(posedge sys_clk_i);
    check({28'h0, seg}, 32'h0000_0000);
    next_seg(4'h1);
    next_seg(4'h2);
    next_seg(4'h0);
    set_en(0);
    wait_run(0);
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, cmp}, 32'h0000_0001);
    set_en(1);
    wait_run(1);
    repeat (3) @(posedge sys_clk_i);
    check({28'h0, seg}, 32'h0000_0001);
    set_en(0);
    wait_run(0);
    repeat (4) @(posedge sys_clk_i);
    bus(1, mps_pkg::ADDR_CTRL, ctl(1, 1, 1, 3, 1, 0));
    set_en(1);
    wait_run(1);
    repeat (3) @(posedge sys_clk_i);
    check({28'h0, seg}, 32'h0000_0000);
    set_en(0);
    wait_run(0);
    repeat (4) @(posedge sys_clk_i);
  endtask
  // Next select value is changed while the current segment runs
  task t_select;
    logic [3:0] sl [4];
    sl = '{4'h2, 4'hF, 4'h1, 4'h0};
    bus(1, mps_pkg::ADDR_CTRL, ctl(1, 2, 1, 1, 0, 1));
    @(posedge sys_clk_i);
    want_sel <= sl[0];
    for (int i = 0; i < 3; i++) begin
      set_en(1);
      wait_run(1);
      want_sel <= sl[i+1];
      wait_run(0);
      check({28'h0, seg}, {28'h0, sl[i]});
      check(pos, disp[sl[i]]);
      set_en(0);
      repeat (4) @(posedge sys_clk_i);
    end
  endtask
  // =========================================================
  // Main sequence and hang guard
  initial begin
    disp[0] = 32'h0000_0004;
    disp[1] = 32'h0000_0003;
    disp[2] = 32'hFFFF_FFFE;
    disp[3] = 32'h0000_0005;
    disp[15] = 32'h0000_0009;
    repeat (4) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    t_defaults;
    t_setup;
    t_source;
    t_single;
    t_cyclic;
    t_select;
    summarize;
  end
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      errors++;
      summarize;
    end
  end
endmodule
